// >>> inc/tct_pkg.sv
`default_nettype none
package tct_pkg;
  localparam int TCT_NUM_TIMERS = 3;
  localparam int TCT_CNT_W = 32;
  localparam int TCT_PRE_W = 16;
  localparam int TCT_SEL_W = 2;
  // timer indices and their interrupt destinations
  localparam int TCT_IDX_EXPANDER = 0;
  localparam int TCT_IDX_LINE13 = 1;
  localparam int TCT_IDX_LINE14 = 2;
  // reset values
  localparam logic [TCT_CNT_W-1:0] TCT_PERIOD_RST = 32'hffffffff;
  localparam logic [TCT_PRE_W-1:0] TCT_PRE_RST = 16'h0000;
  // count clock sources of timer 2
  typedef enum logic [1:0] {
    TCT_SRC_SYSCLK = 2'h0,
    TCT_SRC_OSC1 = 2'h1,
    TCT_SRC_OSC2 = 2'h2,
    TCT_SRC_EXT = 2'h3
  } tct_src_t;
  localparam tct_src_t TCT_SRC_RST = TCT_SRC_SYSCLK;
endpackage
`default_nettype wire

// >>> inc/tct_cfg_if.sv
`timescale 1ns/1ps
`default_nettype none
// configuration and status of one timer channel
interface tct_cfg_if;
  import tct_pkg::*;
  logic [TCT_CNT_W-1:0] period;
  logic [TCT_PRE_W-1:0] prescale;
  logic load;
  logic stop;
  logic tickSrc;
  logic [TCT_CNT_W-1:0] count;
  logic zeroPulse;
  modport ctrl (output period, prescale, load, stop, tickSrc,
                input count, zeroPulse);
  modport chan (input period, prescale, load, stop, tickSrc,
                output count, zeroPulse);
endinterface
`default_nettype wire

// >>> core/tct_channel.sv
`timescale 1ns/1ps
`default_nettype none
module tct_channel
(
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // configuration and status
  tct_cfg_if.chan cfg
);
  import tct_pkg::*;

  logic [TCT_PRE_W-1:0] preCnt_r;
  logic [TCT_PRE_W-1:0] preCnt_nxt;
  logic [TCT_CNT_W-1:0] cnt_r;
  logic [TCT_CNT_W-1:0] cnt_nxt;
  logic zero_r;
  wire tick;
  wire atZero;

  // prescaler reloads with the setting, so a setting of n gives n+1 clocks
  assign tick = cfg.tickSrc && !cfg.stop && (preCnt_r == '0); // R02
  assign preCnt_nxt = (cfg.load || tick) ? cfg.prescale :
                      (cfg.tickSrc && !cfg.stop) ? preCnt_r - 16'h0001 :
                      preCnt_r; // R02
  assign atZero = (cnt_r == '0);
  // at zero the period is reloaded instead of wrapping
  assign cnt_nxt = cfg.load ? cfg.period :
                   !tick ? cnt_r :
                   atZero ? cfg.period : cnt_r - 32'h00000001; // R01 R04

  // counter state
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      preCnt_r <= TCT_PRE_RST;
      cnt_r <= TCT_PERIOD_RST;
      zero_r <= 1'b0;
    end
    else
    begin
      preCnt_r <= preCnt_nxt;
      cnt_r <= cnt_nxt;
      zero_r <= tick && !cfg.load && (cnt_r == 32'h00000001); // R03
    end
  end

  assign cfg.count = cnt_r;
  assign cfg.zeroPulse = zero_r;
endmodule // tct_channel
`default_nettype wire

// >>> core/tct_timers.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// (R01) three identical timers, each a 32-bit down-counter with a preset period
// (R02) counter steps once per tick of clock divided by 16-bit prescale plus one
// (R03) interrupt request raised when a counter reaches zero
// (R04) at zero the counter reloads its period and keeps counting
// (R05) timer 0 interrupt goes to the interrupt expander
// (R06) timer 1 interrupt drives cpu interrupt line thirteen when enabled
// (R07) timer 2 interrupt drives cpu interrupt line fourteen
// (R08) timer 2 counts from system clock, oscillator one, two, or external
// (R09) interrupt stays pending until acknowledged or cleared, never lost
module tct_timers
(
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // configuration, one field per timer for period, prescale, load and stop; line 13 enable and timer 2 source select
  input wire logic [tct_pkg::TCT_NUM_TIMERS*tct_pkg::TCT_CNT_W-1:0] periodIn,
  input wire logic [tct_pkg::TCT_NUM_TIMERS*tct_pkg::TCT_PRE_W-1:0] prescaleIn,
  input wire logic [tct_pkg::TCT_NUM_TIMERS-1:0] loadReq,
  input wire logic [tct_pkg::TCT_NUM_TIMERS-1:0] stopReq,
  input wire logic line13Enable,
  input wire logic [tct_pkg::TCT_SEL_W-1:0] t2SrcSel,
  input wire logic t2SrcWrite,
  // timer 2 alternative count sources, synchronous single-cycle-safe levels
  input wire logic internal_oscillator_one,
  input wire logic internal_oscillator_two,
  input wire logic extClkIn,
  // interrupt acknowledge and clear
  input wire logic [tct_pkg::TCT_NUM_TIMERS-1:0] irqAck,
  // status
  output logic [tct_pkg::TCT_NUM_TIMERS*tct_pkg::TCT_CNT_W-1:0] countOut,
  output logic [tct_pkg::TCT_NUM_TIMERS-1:0] irqPending,
  output logic [tct_pkg::TCT_SEL_W-1:0] t2SrcOut,
  // interrupt lines
  output logic interrupt_expander,
  output logic cpu_irq_line_thirteen,
  output logic cpu_irq_line_fourteen
);
  import tct_pkg::*;

  tct_src_t src_r;
  logic [TCT_NUM_TIMERS-1:0] pend_r;
  logic [TCT_NUM_TIMERS-1:0] pend_nxt;
  logic [TCT_NUM_TIMERS*TCT_CNT_W-1:0] cnt_r;
  logic [2:0] srcLast_r;
  logic exp_r;
  logic l13_r;
  logic l14_r;
  wire [TCT_NUM_TIMERS-1:0] zeroEv;
  wire [TCT_NUM_TIMERS-1:0] tickSrc;
  wire [2:0] srcLvl;
  wire [2:0] srcRise;
  wire t2Tick;
  wire [TCT_NUM_TIMERS*TCT_CNT_W-1:0] cntNow;

  // selected source edge for timer 2; sources are sampled as synchronous
  // levels, so they must run well below half of core_clk
  assign srcLvl = {extClkIn, internal_oscillator_two, internal_oscillator_one};
  assign srcRise = srcLvl & ~srcLast_r;
  assign t2Tick = (src_r == TCT_SRC_SYSCLK) ? 1'b1 :
                  (src_r == TCT_SRC_OSC1) ? srcRise[0] :
                  (src_r == TCT_SRC_OSC2) ? srcRise[1] : srcRise[2]; // R08

  // source select and edge history
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      src_r <= TCT_SRC_RST; // R08
      // history starts at the pin level, so a source idling high
      // gives no false edge right after reset
      srcLast_r <= srcLvl;
    end
    else
    begin
      if (t2SrcWrite)
        src_r <= tct_src_t'(t2SrcSel); // R08
      srcLast_r <= srcLvl;
    end
  end

  // one channel per timer
  genvar gi;
  generate
    for (gi = 0; gi < TCT_NUM_TIMERS; gi++)
    begin : g_chan
      tct_cfg_if cfg ();
      assign cfg.period = periodIn[gi*TCT_CNT_W +: TCT_CNT_W];
      assign cfg.prescale = prescaleIn[gi*TCT_PRE_W +: TCT_PRE_W];
      assign cfg.load = loadReq[gi];
      assign cfg.stop = stopReq[gi];
      assign cfg.tickSrc = tickSrc[gi];
      assign zeroEv[gi] = cfg.zeroPulse;
      assign tickSrc[gi] = (gi == TCT_IDX_LINE14) ? t2Tick : 1'b1;
      tct_channel u_chan
      (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .cfg(cfg)
      ); // R01
      assign cntNow[gi*TCT_CNT_W +: TCT_CNT_W] = cfg.count;
    end
  endgenerate

  // status copy keeps the outputs straight from flip-flops; one process
  // owns the whole vector so no slice has two writers
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
      cnt_r <= {TCT_NUM_TIMERS{TCT_PERIOD_RST}};
    else
      cnt_r <= cntNow;
  end

  // a zero event in the same cycle as an acknowledge wins
  assign pend_nxt = zeroEv | (pend_r & ~irqAck); // R09 R03

  // pending flags and routed lines
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      pend_r <= '0;
      exp_r <= 1'b0;
      l13_r <= 1'b0;
      l14_r <= 1'b0;
    end
    else
    begin
      pend_r <= pend_nxt;
      exp_r <= pend_nxt[TCT_IDX_EXPANDER]; // R05
      l13_r <= pend_nxt[TCT_IDX_LINE13] && line13Enable; // R06
      l14_r <= pend_nxt[TCT_IDX_LINE14]; // R07
    end
  end

  assign countOut = cnt_r;
  assign irqPending = pend_r;
  assign t2SrcOut = src_r;
  assign interrupt_expander = exp_r;
  assign cpu_irq_line_thirteen = l13_r;
  assign cpu_irq_line_fourteen = l14_r;
endmodule // tct_timers
`default_nettype wire

// >>> test/tct_timers_checker.sv
`timescale 1ns/1ps
`default_nettype none
module tct_timers_checker
(
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // watched ports
  input wire logic [95:0] periodIn,
  input wire logic [2:0] stopReq,
  input wire logic [2:0] irqAck,
  input wire logic [1:0] t2SrcSel,
  input wire logic t2SrcWrite,
  input wire logic [95:0] countOut,
  input wire logic [2:0] irqPending,
  input wire logic [1:0] t2SrcOut,
  input wire logic interrupt_expander,
  input wire logic cpu_irq_line_thirteen,
  input wire logic cpu_irq_line_fourteen
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // a rising flag marks a zero event
  sequence hit0;
    $rose(irqPending[0]);
  endsequence
  route_zero_a: assert property (interrupt_expander == irqPending[0])
    else $error("expander line wrong");
  route_fourteen_a: assert property (cpu_irq_line_fourteen == irqPending[2])
    else $error("line fourteen wrong");
  gate_thirteen_a: assert property (cpu_irq_line_thirteen |-> irqPending[1])
    else $error("line thirteen wrong");
  flag_hold_a: assert property (irqPending[1] && !irqAck[1] |=> irqPending[1])
    else $error("flag lost");
  zero_flag_a: assert property ($rose(irqPending[2]) |-> countOut[95:64] == 0)
    else $error("flag without zero");
  reload_period_a: assert property (hit0 |=> countOut[31:0] == periodIn[31:0])
    else $error("no reload");
  source_write_a: assert property (t2SrcWrite |=> t2SrcOut == $past(t2SrcSel))
    else $error("source not taken");
  stop_freeze_a: assert property (stopReq[0] [*2] |=> $stable(countOut[31:0]))
    else $error("count moved");
endmodule // tct_timers_checker
bind tct_timers tct_timers_checker chk (.*);
`default_nettype wire

// >>> test/tct_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module tct_cpu_model
(
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // interrupt lines in, acknowledge out
  input wire logic ackOn,
  input wire logic interrupt_expander,
  input wire logic cpu_irq_line_thirteen,
  input wire logic cpu_irq_line_fourteen,
  output logic [2:0] irqAck
);
  // one pulse per raised line; ackOn low models a busy core
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
      irqAck <= 3'h0;
    else
      irqAck <= {cpu_irq_line_fourteen, cpu_irq_line_thirteen,
                 interrupt_expander} & ~irqAck & {3{ackOn}};
  end
endmodule // tct_cpu_model
`default_nettype wire

// >>> test/tct_timers_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tct_timers_tb;
  logic core_clk = '0, reset_n = '0, line13Enable = '0, ackOn = '0;
  logic t2SrcWrite = '0;
  logic [3:0] srcDiv = '0;
  logic [95:0] periodIn = {3{32'h3}}, countOut;
  logic [47:0] prescaleIn = '0;
  logic [2:0] loadReq = '0, stopReq = '0, irqAck, irqPending;
  logic [1:0] t2SrcSel = '0, t2SrcOut;
  logic interrupt_expander, cpu_irq_line_thirteen, cpu_irq_line_fourteen;
  wire logic internal_oscillator_one = srcDiv[1];
  wire logic internal_oscillator_two = srcDiv[3];
  wire logic extClkIn = srcDiv[2];
  int n_errors = 0, n_compared = 0, cyc = 0;
  tct_timers uut (.*);
  tct_cpu_model cpu (.*);
  // clock, sources rising every 4, 16 and 8 cycles, hang limit
  initial forever #20 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    srcDiv <= srcDiv + 4'h1;
    if (cyc == 3000)
    begin
      n_errors++;
      results;
    end
  end
  task chk(input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task rise(input int i);
    logic p;
    p = 1'h1;
    for (int k = 0; k < 200 && !(irqPending[i] && !p); k++)
    begin
      p = irqPending[i];
      @(posedge core_clk);
    end
  endtask
  // spacing of two zero events, in cycles
  task gap(input int i, input int exp);
    int t0;
    rise(i);
    t0 = cyc;
    rise(i);
    chk(cyc - t0, exp);
  endtask
  task results;
    if (n_errors == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task walkTest;
    periodIn[31:0] <= 32'h2;
    loadReq[0] <= 1'h1;
    @(posedge core_clk);
    loadReq[0] <= 1'h0;
    repeat (2) @(posedge core_clk);
    for (int v = 2; v >= 0; v--)
    begin
      chk(countOut[31:0], v);
      @(posedge core_clk);
    end
    chk(countOut[31:0], 2);
    chk(interrupt_expander, 1);
    stopReq[0] <= 1'h1;
    repeat (6) @(posedge core_clk);
    chk(irqPending[0], 1);
    chk(countOut[31:0], 0);
    stopReq[0] <= 1'h0;
    ackOn <= 1'h1;
  endtask
  // every count source of timer 2; distinct rates catch a swapped select
  task srcTest;
    prescaleIn[47:32] <= 16'h1;
    for (int s = 0; s < 4; s++)
    begin
      @(posedge core_clk);
      t2SrcSel <= 2'(s);
      t2SrcWrite <= 1'h1;
      loadReq[2] <= 1'h1;
      @(posedge core_clk);
      t2SrcWrite <= 1'h0;
      loadReq[2] <= 1'h0;
      gap(2, (s == 0) ? 8 : (s == 1) ? 32 : (s == 2) ? 128 : 64);
      chk(t2SrcOut, s);
    end
  endtask
  task lineTest;
    line13Enable <= 1'h1;
    prescaleIn[31:16] <= 16'h2;
    loadReq[1] <= 1'h1;
    @(posedge core_clk);
    loadReq[1] <= 1'h0;
    gap(1, 12);
    chk(cpu_irq_line_thirteen, 1);
    line13Enable <= 1'h0;
    repeat (30) @(posedge core_clk);
    chk(irqPending[1], 1);
    chk(cpu_irq_line_thirteen, 0);
  endtask
  initial
  begin
    repeat (6) @(posedge core_clk);
    reset_n <= 1'h1;
    walkTest;
    srcTest;
    lineTest;
    results;
  end
endmodule // tct_timers_tb
`default_nettype wire
